// [core/maintenance_hours_counter.v]
// maintenance hours counter with axi4-lite register slave
// Contract
// - reset rising edge clears expiry and reloads time-to-go; run hours untouched
// - reset-all rising edge clears expiry, zeroes run hours, reloads time-to-go
// - counters advance only while enable is high, hold otherwise
// - expiry goes high when time-to-go is zero, stays until cleared
// - clear mode: reset only, or also clear expiry while enable low
// - interval set in hours and minutes, up to 9999 h 59 m
// - run time in hours and minutes, up to 99999 h 59 m, presettable
// - run time keeps counting while enabled even if reset held
// - run time saturates at 99999 hours and stops there
// - preset gives time-to-go as interval minus run time modulo interval
// - interval change loads time-to-go with new interval directly
// - run time preset only accepted in configuration mode
// - interval kept by every control reset; time-to-go reloaded by both, run time zeroed by reset-all
// - interval taken from fixed setting or live input
`timescale 1ns/10ps
`default_nettype none
`include "mhc_consts.vh"

module maintenance_hours_counter #(
	parameter [`PRESC_W-1:0] TICK_CYCLES = `TICK_CYCLES
) (
	// clock, reset, clock enable
	input wire clk,
	input wire reset_n,
	input wire ce,
	// control logic inputs
	input wire en,
	input wire rst_in,
	input wire rst_all_in,
	input wire [`TTG_W-1:0] live_interval,
	// outputs
	output reg expired,
	output reg irq,
	// axi4-lite write address
	input wire [`ADDR_W-1:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output reg s_axi_awready,
	// axi4-lite write data
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output reg s_axi_wready,
	// axi4-lite write response
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	// axi4-lite read address
	input wire [`ADDR_W-1:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output reg s_axi_arready,
	// axi4-lite read data
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready
);

// hours/minutes word to minutes, each field clamped
function [`RUN_W-1:0] hm_to_min;
	input [31:0] word;
	input [`HOURS_W-1:0] hmax;
	reg [`HOURS_W-1:0] h;
	reg [`MINS_W-1:0] m;
	begin
		h = word[`HM_HOUR_LSB +: `HOURS_W];
		m = word[`HM_MIN_LSB +: `MINS_W];
		if (h > hmax)
			h = hmax;
		if (m > `MINS_MAX)
			m = `MINS_MAX;
		hm_to_min = {6'h00, h} * `MIN_PER_HOUR + {17'h00000, m};
	end
endfunction

// hours/minutes word with each field clamped, unused bits read as zero
function [31:0] hm_clamp;
	input [31:0] word;
	input [`HOURS_W-1:0] hmax;
	reg [`HOURS_W-1:0] h;
	reg [`MINS_W-1:0] m;
	begin
		h = word[`HM_HOUR_LSB +: `HOURS_W];
		m = word[`HM_MIN_LSB +: `MINS_W];
		if (h > hmax)
			h = hmax;
		if (m > `MINS_MAX)
			m = `MINS_MAX;
		hm_clamp = 32'h00000000;
		hm_clamp[`HM_HOUR_LSB +: `HOURS_W] = h;
		hm_clamp[`HM_MIN_LSB +: `MINS_W] = m;
	end
endfunction

// byte-lane merge of a write
function [31:0] merge_strb;
	input [31:0] old;
	input [31:0] data;
	input [3:0] strb;
	integer i;
	begin
		merge_strb = old;
		for (i = 0; i < 4; i = i + 1) begin
			if (strb[i])
				merge_strb[i*8 +: 8] = data[i*8 +: 8];
		end
	end
endfunction

// word offset of a byte address
function [`ADDR_W-1:0] word_ofs;
	input [`ADDR_W-1:0] a;
	begin
		word_ofs = {a[`ADDR_W-1:2], 2'b00};
	end
endfunction

// true when an offset names a register
function mapped;
	input [`ADDR_W-1:0] a;
	begin
		case (word_ofs(a))
			`OFS_CTRL, `OFS_INTERVAL, `OFS_PRESET, `OFS_STATUS,
			`OFS_TTG, `OFS_RUN, `OFS_IRQ_STAT, `OFS_IRQ_MASK: mapped = 1'b1;
			default: mapped = 1'b0;
		endcase
	end
endfunction

// registers
reg [`CTRL_W-1:0] ctrl_reg;
reg [31:0] interval_reg;
reg [31:0] preset_reg;
reg [`IRQ_W-1:0] irq_stat_reg;
reg [`IRQ_W-1:0] irq_mask_reg;
reg [`TTG_W-1:0] ttg_reg;
reg [`RUN_W-1:0] run_reg;
reg [`TTG_W-1:0] interval_prev_reg;
reg rst_prev_reg;
reg rst_all_prev_reg;

// bus holding state
reg aw_full_reg;
reg w_full_reg;
reg [`ADDR_W-1:0] waddr_reg;
reg [31:0] wdata_reg;
reg [3:0] wstrb_reg;

wire tick;
wire [`ADDR_W-1:0] waddr_al = word_ofs(waddr_reg);
wire [`ADDR_W-1:0] raddr_al = word_ofs(s_axi_araddr);
wire wr_fire = aw_full_reg & w_full_reg & ~s_axi_bvalid;
wire clr_on_en_low = ctrl_reg[`CTRL_CLR_ON_EN_LOW];
wire live_sel = ctrl_reg[`CTRL_LIVE_SEL];
wire config_mode = ctrl_reg[`CTRL_CONFIG_MODE];

minute_prescaler #(
	.TICK_CYCLES(TICK_CYCLES)
) u_presc (
	.clk(clk),
	.reset_n(reset_n),
	.ce(ce),
	.tick(tick)
);

// selected interval in minutes
wire [`RUN_W-1:0] fixed_min = hm_to_min(interval_reg, `INTERVAL_HOURS_MAX);
wire [`TTG_W-1:0] live_min = (live_interval > `TTG_MAX) ? `TTG_MAX : live_interval;
wire [`TTG_W-1:0] interval_sel = live_sel ? live_min : fixed_min[`TTG_W-1:0];

// preset path
wire [`RUN_W-1:0] preset_min = hm_to_min(wdata_reg, `RUN_HOURS_MAX);
wire [`RUN_W-1:0] preset_rem = (interval_sel == {`TTG_W{1'b0}}) ? {`RUN_W{1'b0}} :
	preset_min % {3'b000, interval_sel};
wire [`TTG_W-1:0] preset_ttg = interval_sel - preset_rem[`TTG_W-1:0];
wire preset_go = wr_fire & (waddr_al == `OFS_PRESET) & config_mode;

// event detection
wire rst_rise = rst_in & ~rst_prev_reg;
wire rst_all_rise = rst_all_in & ~rst_all_prev_reg;
wire step = tick & en;
wire saturated = run_reg >= `RUN_SAT;
wire clear_cond = rst_in | rst_all_in | (clr_on_en_low & ~en);
wire expired_next = clear_cond ? 1'b0 : (expired | (ttg_reg == {`TTG_W{1'b0}}));
wire sat_next = (run_reg + 1'b1) >= `RUN_SAT;

// interrupt status: set wins over write-one clear
wire [`IRQ_W-1:0] irq_set;
assign irq_set[`IRQ_EXPIRED] = expired_next & ~expired;
assign irq_set[`IRQ_SATURATED] = step & ~saturated & sat_next;
assign irq_set[`IRQ_RESET_ALL] = rst_all_rise;
wire [`IRQ_W-1:0] irq_clr = (wr_fire && waddr_al == `OFS_IRQ_STAT && wstrb_reg[0]) ?
	wdata_reg[`IRQ_W-1:0] : {`IRQ_W{1'b0}};
wire [`IRQ_W-1:0] irq_stat_next = (irq_stat_reg & ~irq_clr) | irq_set;

// counters
always @(posedge clk or negedge reset_n) begin
	if (!reset_n) begin
		ttg_reg <= {`TTG_W{1'b0}};
		run_reg <= {`RUN_W{1'b0}};
		interval_prev_reg <= {`TTG_W{1'b0}};
		rst_prev_reg <= 1'b0;
		rst_all_prev_reg <= 1'b0;
		expired <= 1'b0;
	end else if (ce) begin
		rst_prev_reg <= rst_in;
		rst_all_prev_reg <= rst_all_in;
		interval_prev_reg <= interval_sel;
		expired <= expired_next;
		// time-to-go
		if (rst_rise | rst_all_rise) begin
			ttg_reg <= interval_sel;
		end else if (preset_go) begin
			ttg_reg <= preset_ttg;
		end else if (interval_sel != interval_prev_reg) begin
			ttg_reg <= interval_sel;
		end else if (step && ttg_reg != {`TTG_W{1'b0}}) begin
			ttg_reg <= ttg_reg - 1'b1;
		end
		// run time, untouched by the plain reset
		if (rst_all_rise) begin
			run_reg <= {`RUN_W{1'b0}};
		end else if (preset_go) begin
			run_reg <= preset_min;
		end else if (step && !saturated) begin
			run_reg <= run_reg + 1'b1;
		end
	end
end

// register writes
always @(posedge clk or negedge reset_n) begin
	if (!reset_n) begin
		ctrl_reg <= `CTRL_RESET;
		interval_reg <= `HM_RESET;
		preset_reg <= `HM_RESET;
		irq_stat_reg <= {`IRQ_W{1'b0}};
		irq_mask_reg <= {`IRQ_W{1'b0}};
		irq <= 1'b0;
	end else if (ce) begin
		irq_stat_reg <= irq_stat_next;
		irq <= |(irq_stat_next & irq_mask_reg);
		if (wr_fire) begin
			case (waddr_al)
				`OFS_CTRL: begin
					if (wstrb_reg[0])
						ctrl_reg <= wdata_reg[`CTRL_W-1:0];
				end
				`OFS_INTERVAL: begin
					interval_reg <= hm_clamp(merge_strb(interval_reg, wdata_reg, wstrb_reg),
						`INTERVAL_HOURS_MAX);
				end
				`OFS_PRESET: begin
					if (config_mode)
						preset_reg <= hm_clamp(wdata_reg, `RUN_HOURS_MAX);
				end
				`OFS_IRQ_MASK: begin
					if (wstrb_reg[0])
						irq_mask_reg <= wdata_reg[`IRQ_W-1:0];
				end
				default: begin
				end
			endcase
		end
	end
end

// write channels: address and data in either order
always @(posedge clk or negedge reset_n) begin
	if (!reset_n) begin
		s_axi_awready <= 1'b1;
		s_axi_wready <= 1'b1;
		aw_full_reg <= 1'b0;
		w_full_reg <= 1'b0;
		waddr_reg <= {`ADDR_W{1'b0}};
		wdata_reg <= 32'h00000000;
		wstrb_reg <= 4'h0;
		s_axi_bvalid <= 1'b0;
		s_axi_bresp <= `RESP_OKAY;
	end else if (ce) begin
		if (s_axi_awvalid && s_axi_awready) begin
			waddr_reg <= s_axi_awaddr;
			aw_full_reg <= 1'b1;
			s_axi_awready <= 1'b0;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			wdata_reg <= s_axi_wdata;
			wstrb_reg <= s_axi_wstrb;
			w_full_reg <= 1'b1;
			s_axi_wready <= 1'b0;
		end
		if (wr_fire) begin
			aw_full_reg <= 1'b0;
			w_full_reg <= 1'b0;
			s_axi_bvalid <= 1'b1;
			if (!mapped(waddr_reg))
				s_axi_bresp <= `RESP_SLVERR;
			else if (waddr_al == `OFS_PRESET && !config_mode)
				s_axi_bresp <= `RESP_SLVERR;
			else
				s_axi_bresp <= `RESP_OKAY;
		end
		if (s_axi_bvalid && s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
		end
	end
end

// read channel
always @(posedge clk or negedge reset_n) begin
	if (!reset_n) begin
		s_axi_arready <= 1'b1;
		s_axi_rvalid <= 1'b0;
		s_axi_rdata <= 32'h00000000;
		s_axi_rresp <= `RESP_OKAY;
	end else if (ce) begin
		if (s_axi_arvalid && s_axi_arready) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b1;
			s_axi_rresp <= mapped(s_axi_araddr) ? `RESP_OKAY : `RESP_SLVERR;
			case (raddr_al)
				`OFS_CTRL: s_axi_rdata <= {29'h00000000, ctrl_reg};
				`OFS_INTERVAL: s_axi_rdata <= interval_reg;
				`OFS_PRESET: s_axi_rdata <= preset_reg;
				`OFS_STATUS: s_axi_rdata <= {28'h0000000, config_mode, saturated, en, expired};
				`OFS_TTG: s_axi_rdata <= {12'h000, ttg_reg};
				`OFS_RUN: s_axi_rdata <= {9'h000, run_reg};
				`OFS_IRQ_STAT: s_axi_rdata <= {29'h00000000, irq_stat_reg};
				`OFS_IRQ_MASK: s_axi_rdata <= {29'h00000000, irq_mask_reg};
				default: s_axi_rdata <= 32'h00000000;
			endcase
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end
end

endmodule
`default_nettype wire

// [core/mhc_consts.vh]
// constants for the maintenance hours counter
`ifndef MHC_CONSTS_VH
`define MHC_CONSTS_VH

// timing
`define CLK_HZ 25000000
`define MINUTE_S 60
`define TICK_CYCLES (`MINUTE_S * `CLK_HZ)
`define PRESC_W 31

// value widths and limits, in minutes except the hours fields and limits
`define RUN_W 23
`define TTG_W 20
`define HOURS_W 17
`define MINS_W 6
`define MIN_PER_HOUR 23'h00003c
`define MINS_MAX 6'h3b
`define INTERVAL_HOURS_MAX 17'h0270f
`define RUN_HOURS_MAX 17'h1869f
`define TTG_MAX 20'h927bf
`define RUN_SAT 23'h5b8d44

// register byte offsets
`define ADDR_W 5
`define OFS_CTRL 5'h00
`define OFS_INTERVAL 5'h04
`define OFS_PRESET 5'h08
`define OFS_STATUS 5'h0c
`define OFS_TTG 5'h10
`define OFS_RUN 5'h14
`define OFS_IRQ_STAT 5'h18
`define OFS_IRQ_MASK 5'h1c

// control fields
`define CTRL_CLR_ON_EN_LOW 0
`define CTRL_LIVE_SEL 1
`define CTRL_CONFIG_MODE 2
`define CTRL_W 3

// hours/minutes register layout
`define HM_MIN_LSB 0
`define HM_HOUR_LSB 8

// interrupt bits
`define IRQ_EXPIRED 0
`define IRQ_SATURATED 1
`define IRQ_RESET_ALL 2
`define IRQ_W 3

// reset values
`define CTRL_RESET 3'h0
`define HM_RESET 32'h00000000

// bus responses
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// [core/minute_prescaler.v]
// one-cycle tick every TICK_CYCLES clock cycles
`timescale 1ns/10ps
`default_nettype none
`include "mhc_consts.vh"

module minute_prescaler #(
	parameter [`PRESC_W-1:0] TICK_CYCLES = `TICK_CYCLES
) (
	// clock and reset
	input wire clk,
	input wire reset_n,
	input wire ce,
	// tick out
	output reg tick
);

reg [`PRESC_W-1:0] count_reg;

always @(posedge clk or negedge reset_n) begin
	if (!reset_n) begin
		count_reg <= {`PRESC_W{1'b0}};
		tick <= 1'b0;
	end else if (ce) begin
		if (count_reg >= TICK_CYCLES - 1'b1) begin
			count_reg <= {`PRESC_W{1'b0}};
			tick <= 1'b1;
		end else begin
			count_reg <= count_reg + 1'b1;
			tick <= 1'b0;
		end
	end
end

endmodule
`default_nettype wire

// [sim/ctrl_model.sv]
// surrounding control logic driving enable and the two resets
`timescale 1ns/10ps
`default_nettype none
module ctrl_model (
	// clock
	input wire logic clk,
	// control outputs
	output logic en,
	output logic rst_in,
	output logic rst_all_in
);
	initial begin
		en = 1'b0;
		rst_in = 1'b0;
		rst_all_in = 1'b0;
	end
	task set_en(input logic v);
		en <= v;
	endtask
	task set_rst(input logic v);
		rst_in <= v;
	endtask
	// one-cycle pulse, then a quiet cycle before the next edge
	task pulse(input logic all);
		@(posedge clk);
		if (all)
			rst_all_in <= 1'b1;
		else
			rst_in <= 1'b1;
		@(posedge clk);
		rst_in <= 1'b0;
		rst_all_in <= 1'b0;
		@(posedge clk);
	endtask
endmodule
`default_nettype wire

// [sim/mhc_sva.sv]
// assertions on the hours counter ports
`timescale 1ns/10ps
`default_nettype none
module mhc_sva (
	// clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// control and output
	input wire logic en,
	input wire logic rst_in,
	input wire logic rst_all_in,
	input wire logic expired,
	// bus
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [31:0] s_axi_rdata
);
	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);
	sequence wr_take;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence b_wait;
		s_axi_bvalid && !s_axi_bready;
	endsequence
	a_rst_clear: assert property (rst_in |=> !expired)
		else $error("expired not cleared by reset");
	a_ral_clear: assert property (rst_all_in |=> !expired)
		else $error("expired not cleared by reset-all");
	a_exp_hold: assert property (expired && en && !rst_in && !rst_all_in |=> expired)
		else $error("expired dropped without cause");
	a_exp_cause: assert property ($rose(expired) |-> !$past(rst_in) && !$past(rst_all_in))
		else $error("expired rose under reset");
	a_wr_answer: assert property (wr_take |=> ##1 s_axi_bvalid)
		else $error("write response late");
	a_b_hold: assert property (b_wait |=> s_axi_bvalid)
		else $error("write response dropped");
	a_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
		else $error("read answer late");
	a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data not held");
endmodule
bind maintenance_hours_counter mhc_sva u_sva (.*);
`default_nettype wire

// [sim/maintenance_hours_counter_tb_top.sv]
// bench for the maintenance hours counter
`timescale 1ns/10ps
`default_nettype none
`include "mhc_consts.vh"
module maintenance_hours_counter_tb_top;
	logic clk, reset_n, ce, aw, wv, br, ar, rr, awready, wready, bvalid, arready, rvalid, expired, irq;
	logic [3:0] wstrb;
	logic [4:0] awaddr, araddr;
	logic [31:0] wdata, rdata, v;
	logic [19:0] live;
	logic [1:0] bresp, rresp;
	logic [33:0] q[$];
	wire en, rst_in, rst_all_in;
	int err_count, total_checks, n;
	maintenance_hours_counter #(.TICK_CYCLES(31'h4)) uut (.clk(clk), .reset_n(reset_n),
		.ce(ce), .en(en), .rst_in(rst_in), .rst_all_in(rst_all_in), .live_interval(live),
		.expired(expired), .irq(irq), .s_axi_awaddr(awaddr), .s_axi_awvalid(aw),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wv),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(br),
		.s_axi_araddr(araddr), .s_axi_arvalid(ar), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rr));
	ctrl_model u_ctrl (.clk(clk), .en(en), .rst_in(rst_in), .rst_all_in(rst_all_in));
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	task chk(input logic [33:0] s, input logic [33:0] e);
		total_checks++;
		if (s !== e) begin
			err_count++;
			$display("[ERR] %0t got %h exp %h", $time, s, e);
		end
	endtask
	task test_done;
		$display("checks %0d errors %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task wr(input logic [4:0] a, input logic [31:0] d, input logic [1:0] r);
		logic pa, pw;
		pa = 1'b1;
		pw = 1'b1;
		q.push_back({r, 32'h0});
		@(posedge clk);
		awaddr <= a;
		wdata <= d;
		aw <= 1'b1;
		wv <= 1'b1;
		while (pa || pw) begin
			@(posedge clk);
			if (pa && awready) begin
				pa = 1'b0;
				aw <= 1'b0;
			end
			if (pw && wready) begin
				pw = 1'b0;
				wv <= 1'b0;
			end
		end
		repeat ($urandom % 3) @(posedge clk);
		br <= 1'b1;
		do @(posedge clk); while (!bvalid);
		br <= 1'b0;
	endtask
	task rd(input logic [4:0] a, input logic [31:0] e);
		q.push_back({2'h0, e});
		@(posedge clk);
		araddr <= a;
		ar <= 1'b1;
		do @(posedge clk); while (!arready);
		ar <= 1'b0;
		repeat ($urandom % 2) @(posedge clk);
		rr <= 1'b1;
		do @(posedge clk); while (!rvalid);
		rr <= 1'b0;
	endtask
	task irq_is(input logic e);
		repeat (2) @(posedge clk);
		chk({33'h0, irq}, {33'h0, e});
	endtask
	task run_exp;
		u_ctrl.set_en(1'b1);
		@(posedge expired);
		repeat (2) @(posedge clk);
		u_ctrl.set_en(1'b0);
	endtask
	task tend;
		n++;
		$display("test %0d done", n);
	endtask
	// monitor: every answer takes the oldest note
	always @(posedge clk) begin
		if (rvalid && rr)
			chk({rresp, rdata}, q.pop_front());
		if (bvalid && br)
			chk({bresp, 32'h0}, q.pop_front());
	end
	initial begin
		repeat (20000) @(posedge clk);
		err_count++;
		test_done;
	end
	initial begin
		{reset_n, aw, wv, br, ar, rr, awaddr, araddr, wdata, live} = '0;
		ce = 1'b1;
		wstrb = 4'hf;
		err_count = 0;
		total_checks = 0;
		n = 0;
		v = $urandom(97700);
		repeat (2) @(posedge clk);
		reset_n <= 1'b1;
		rd(`OFS_CTRL, 32'h0);
		rd(`OFS_STATUS, 32'h1);
		tend;
		wr(`OFS_CTRL, 32'h4, `RESP_OKAY);
		wr(`OFS_INTERVAL, 32'h11e, `RESP_OKAY);
		wr(`OFS_PRESET, 32'h314, `RESP_OKAY);
		rd(`OFS_TTG, 32'h46);
		rd(`OFS_RUN, 32'hc8);
		wr(`OFS_INTERVAL, 32'h1ffff3f, `RESP_OKAY);
		rd(`OFS_INTERVAL, 32'h270f3b);
		rd(`OFS_TTG, 32'h927bf);
		wr(`OFS_CTRL, 32'h0, `RESP_OKAY);
		wr(`OFS_PRESET, 32'h0, `RESP_SLVERR);
		rd(`OFS_RUN, 32'hc8);
		tend;
		wr(`OFS_INTERVAL, 32'h3, `RESP_OKAY);
		u_ctrl.pulse(1'b0);
		rd(`OFS_TTG, 32'h3);
		run_exp;
		rd(`OFS_TTG, 32'h0);
		rd(`OFS_RUN, 32'hcb);
		repeat (20) @(posedge clk);
		rd(`OFS_RUN, 32'hcb);
		rd(`OFS_STATUS, 32'h1);
		u_ctrl.pulse(1'b0);
		rd(`OFS_STATUS, 32'h0);
		rd(`OFS_TTG, 32'h3);
		rd(`OFS_RUN, 32'hcb);
		wr(`OFS_CTRL, 32'h1, `RESP_OKAY);
		run_exp;
		rd(`OFS_STATUS, 32'h0);
		rd(`OFS_RUN, 32'hce);
		tend;
		rd(`OFS_IRQ_STAT, 32'h1);
		irq_is(1'b0);
		wr(`OFS_IRQ_MASK, 32'h1, `RESP_OKAY);
		irq_is(1'b1);
		wr(`OFS_IRQ_STAT, 32'h1, `RESP_OKAY);
		rd(`OFS_IRQ_STAT, 32'h0);
		irq_is(1'b0);
		u_ctrl.pulse(1'b1);
		rd(`OFS_RUN, 32'h0);
		rd(`OFS_TTG, 32'h3);
		rd(`OFS_IRQ_STAT, 32'h4);
		wr(`OFS_IRQ_MASK, 32'h4, `RESP_OKAY);
		irq_is(1'b1);
		wr(`OFS_IRQ_STAT, 32'h4, `RESP_OKAY);
		// eight edges hold exactly two ticks; reset held high must not stop run time
		u_ctrl.set_en(1'b1);
		u_ctrl.set_rst(1'b1);
		repeat (8) @(posedge clk);
		u_ctrl.set_en(1'b0);
		u_ctrl.set_rst(1'b0);
		rd(`OFS_RUN, 32'h2);
		tend;
		wr(`OFS_CTRL, 32'h4, `RESP_OKAY);
		wr(`OFS_INTERVAL, 32'h7, `RESP_OKAY);
		wr(`OFS_PRESET, 32'h1869e3b, `RESP_OKAY);
		rd(`OFS_TTG, 32'h6);
		wr(`OFS_CTRL, 32'h0, `RESP_OKAY);
		run_exp;
		rd(`OFS_RUN, 32'h5b8d44);
		rd(`OFS_STATUS, 32'h5);
		rd(`OFS_IRQ_STAT, 32'h3);
		// lane 0 only: the hours field keeps its old zero
		wstrb <= 4'h1;
		wr(`OFS_INTERVAL, 32'h00000205, `RESP_OKAY);
		wstrb <= 4'hf;
		rd(`OFS_INTERVAL, 32'h5);
		rd(`OFS_TTG, 32'h5);
		// clock enable low freezes counting even with enable high
		ce <= 1'b0;
		u_ctrl.set_en(1'b1);
		repeat (12) @(posedge clk);
		ce <= 1'b1;
		u_ctrl.set_en(1'b0);
		rd(`OFS_TTG, 32'h5);
		tend;
		wr(`OFS_CTRL, 32'h2, `RESP_OKAY);
		repeat (3) begin
			@(posedge clk);
			v = $urandom % 600000;
			live <= v[19:0];
			repeat (2) @(posedge clk);
			rd(`OFS_TTG, v);
		end
		tend;
		test_done;
	end
endmodule
`default_nettype wire
